// ==== pkg/overcurrent_defines.svh ====
// Purpose: offsets, fields, reset values and timing counts
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef OVERCURRENT_DEFINES_SVH
`define OVERCURRENT_DEFINES_SVH
`define OFS_CTRL 8'h00
`define OFS_START 8'h04
`define OFS_DELAY 8'h08
`define OFS_ANGLE 8'h0C
`define OFS_RATED 8'h10
`define OFS_STATUS 8'h14
`define CTRL_EN_BIT 0
`define CTRL_ISO_BIT 1
`define CTRL_DIR_LSB 2
`define CTRL_FALLBACK_BIT 4
`define CTRL_RMS_BIT 5
`define CTRL_INV_BIT 6
`define CTRL_RESET 32'h0000_0004
`define START_RESET 16'h0100
`define DELAY_RESET 16'h0064
`define ANGLE_RESET 16'h3C3C
`define RATED_RESET 32'h03E8_03E8
`define PCT_SCALE 24'h00_0064
`define VMIN_PCT 24'h00_0005
`define IMIN_PCT 24'h00_0008
`define TICK_NS 1000000
`define CLK_NS 100
`endif

// ==== pkg/overcurrent_pkg.sv ====
// Purpose: shared types of the directional overcurrent block
// Assumes: nothing
// Notes: encodings follow declaration order
package overcurrent_pkg;
	typedef enum logic [1:0] {DIR_NONDIR, DIR_FORWARD, DIR_BACKWARD} dir_mode_t;
	typedef enum logic [1:0] {TM_IDLE, TM_RUN, TM_TRIP} timer_state_t;
endpackage

// ==== core/directional_overcurrent_function.sv ====
// Purpose: directional three-phase overcurrent decision with APB settings
// Assumes: measurement inputs and binary inputs come from logic on pclk
// Notes: loops 0..2 phase-to-phase, 3..5 phase-to-neutral; angles signed degrees
//
// Overview of operation
// - pick the qualifying loop with smallest impedance among six loops
// - loop qualifies when voltage above 5% and current at least 8% rated
// - isolated grounding setting restricts selection to phase-to-phase loops
// - directional enable only when voltage and current minimum both met
// - selected loop voltage and current feed the angle stage
// - angle is voltage angle minus current angle
// - direction true only with sufficient quantities and angle inside window
// - direction mode forward, backward or non-directional
// - weak loop voltage falls back to positive sequence, then stored voltage
// - setting picks RMS or fundamental magnitudes for overcurrent
// - time characteristic is definite or inverse
// - trip needs direction, current above setting and elapsed delay
// - inhibit input suppresses start and trip
// - supervision alarm disables directional operation
// - switch-onto-fault skips direction check and delay
// - enable setting off suppresses start and trip
// - outputs are three phase starts, general start and trip
// - direction result gates the overcurrent start and trip
// - direction setting encodes three values, forward after reset
// - alarm response setting: fall back to non-directional or block, block default
//
// The APB slave port and the register addresses were decided locally.
`include "overcurrent_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module directional_overcurrent_function #(
	parameter int TICK_CYCLES = `TICK_NS / `CLK_NS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic meas_valid,
	input wire logic [5:0][15:0] loop_v_mag,
	input wire logic [5:0][8:0] loop_v_ang,
	input wire logic [5:0][15:0] loop_i_mag,
	input wire logic [5:0][8:0] loop_i_ang,
	input wire logic [15:0] posseq_v_mag,
	input wire logic [8:0] posseq_v_ang,
	input wire logic [2:0][15:0] phase_i_rms,
	input wire logic [2:0][15:0] phase_i_fourier,
	input wire logic inhibit,
	input wire logic voltage_transformer_supervision_alarm,
	input wire logic switch_onto_fault_condition,
	output logic [2:0] start_phase,
	output logic general_start,
	output logic trip
);
	// sign extension of an angle to arithmetic width
	function automatic logic signed [10:0] sx(input logic [8:0] v);
		return signed'({{2{v[8]}}, v});
	endfunction
	// fold into -180..179
	function automatic logic signed [8:0] wrap_deg(input logic signed [10:0] a);
		logic signed [10:0] t;
		t = a;
		if (t >= 11'sh0B4) begin
			t = t - 11'sh168;
		end else if (t < -11'sh0B4) begin
			t = t + 11'sh168;
		end
		return t[8:0];
	endfunction
	// true when ang lies within roa degrees of ctr
	function automatic logic in_window(input logic [8:0] ang, input logic [8:0] ctr, input logic [7:0] roa);
		logic signed [8:0] d;
		logic [8:0] m;
		d = wrap_deg(sx(ang) - sx(ctr));
		m = d[8] ? 9'(-d) : 9'(d);
		return m <= {1'b0, roa};
	endfunction
	// magnitude against a percentage of rated
	function automatic logic pct_ok(input logic [15:0] mag, input logic [15:0] rated, input logic [23:0] pct,
		input logic strict);
		logic [23:0] l;
		logic [23:0] r;
		l = 24'(mag) * `PCT_SCALE;
		r = 24'(rated) * pct;
		return strict ? (l > r) : (l >= r);
	endfunction
	// impedance a below b without division
	function automatic logic z_less(input logic [15:0] va, input logic [15:0] ia, input logic [15:0] vb,
		input logic [15:0] ib);
		return (32'(va) * 32'(ib)) < (32'(vb) * 32'(ia));
	endfunction

	logic [31:0] ctrl_reg, ctrl_next;
	logic [15:0] start_reg, start_next, delay_reg, delay_next, angle_reg, angle_next;
	logic [31:0] rated_reg, rated_next, prdata_reg, prdata_next;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic wr_en, setup;
	overcurrent_pkg::dir_mode_t dir_mode;
	assign dir_mode = overcurrent_pkg::dir_mode_t'(ctrl_reg[`CTRL_DIR_LSB +: 2]);
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready_reg && pwrite;

	logic [2:0] start_phase_reg, start_phase_next;
	logic gstart_reg, gstart_next, trip_reg, trip_next, sotf_reg, sotf_next;
	logic dir_ok_reg, dir_ok_next, dir_en_reg, dir_en_next, found_reg, found_next;
	logic [2:0] sel_reg, sel_next;
	logic [8:0] angle_out_reg, angle_out_next, mem_ang_reg, mem_ang_next;
	logic mem_valid_reg, mem_valid_next, blocked_reg, blocked_next;
	logic [15:0] excess_reg, excess_next;
	overcurrent_pkg::timer_state_t tm_reg, tm_next;
	logic [15:0] tick_reg, tick_next;
	logic [31:0] acc_reg, acc_next, thr;

	// slave answers one cycle after setup, so every access has one wait-free access phase
	always_comb begin
		ctrl_next = ctrl_reg;
		start_next = start_reg;
		delay_next = delay_reg;
		angle_next = angle_reg;
		rated_next = rated_reg;
		pready_next = setup;
		pslverr_next = 1'b0;
		prdata_next = 32'h0000_0000;
		if (setup) begin
			case (paddr)
				`OFS_CTRL: prdata_next = {25'h000_0000, ctrl_reg[6:0]};
				`OFS_START: prdata_next = {16'h0000, start_reg};
				`OFS_DELAY: prdata_next = {16'h0000, delay_reg};
				`OFS_ANGLE: prdata_next = {16'h0000, angle_reg};
				`OFS_RATED: prdata_next = rated_reg;
				`OFS_STATUS: prdata_next = {7'h00, angle_out_reg, 5'h00, found_reg, dir_en_reg, dir_ok_reg,
					sel_reg, trip_reg, gstart_reg, start_phase_reg};
				default: pslverr_next = 1'b1;
			endcase
			// status is read only, so a write to it answers with an error
			if (pwrite && paddr == `OFS_STATUS) begin
				pslverr_next = 1'b1;
			end
		end else begin
			pslverr_next = pslverr_reg && !pready_reg ? 1'b0 : 1'b0;
		end
		if (wr_en && !pslverr_reg) begin
			case (paddr)
				`OFS_CTRL: ctrl_next = {25'h000_0000, pwdata[6:0]};
				`OFS_START: start_next = pwdata[15:0];
				`OFS_DELAY: delay_next = pwdata[15:0];
				`OFS_ANGLE: angle_next = pwdata[15:0];
				`OFS_RATED: rated_next = pwdata;
				default: ctrl_next = ctrl_reg;
			endcase
		end
	end

	// forward direction and blocking alarm response after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `CTRL_RESET;
			start_reg <= `START_RESET;
			delay_reg <= `DELAY_RESET;
			angle_reg <= `ANGLE_RESET;
			rated_reg <= `RATED_RESET;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			start_reg <= start_next;
			delay_reg <= delay_next;
			angle_reg <= angle_next;
			rated_reg <= rated_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// evaluation of one measurement set
	logic [2:0] bf, bc;
	logic ff, fc, v_ok, i_ok, pos_ok, pol_ok, nondir, win, use_full;
	logic [2:0] s;
	logic [8:0] pol_ang, ang;
	logic [15:0] mag, maxmag;
	logic [2:0] st;
	always_comb begin
		bf = 3'h0;
		bc = 3'h0;
		ff = 1'b0;
		fc = 1'b0;
		for (int k = 0; k < 6; k++) begin
			v_ok = pct_ok(loop_v_mag[k], rated_reg[15:0], `VMIN_PCT, 1'b1);
			i_ok = pct_ok(loop_i_mag[k], rated_reg[31:16], `IMIN_PCT, 1'b0);
			// neutral loops dropped on isolated networks
			if (i_ok && (k < 3 || !ctrl_reg[`CTRL_ISO_BIT])) begin
				if (v_ok && (!ff || z_less(loop_v_mag[k], loop_i_mag[k], loop_v_mag[bf], loop_i_mag[bf]))) begin
					ff = 1'b1;
					bf = 3'(k);
				end
				// current-only candidates, used when no loop has enough voltage
				if (!fc || z_less(loop_v_mag[k], loop_i_mag[k], loop_v_mag[bc], loop_i_mag[bc])) begin
					fc = 1'b1;
					bc = 3'(k);
				end
			end
		end
		use_full = ff;
		s = use_full ? bf : bc;
		pos_ok = pct_ok(posseq_v_mag, rated_reg[15:0], `VMIN_PCT, 1'b1);
		pol_ang = use_full ? loop_v_ang[s] : (pos_ok ? posseq_v_ang : mem_ang_reg);
		pol_ok = use_full || pos_ok || mem_valid_reg;
		// selected loop angle with current as reference
		ang = 9'(wrap_deg(sx(pol_ang) - sx(loop_i_ang[s])));
		// non-directional by setting or alarm fallback
		nondir = dir_mode == overcurrent_pkg::DIR_NONDIR ||
			(voltage_transformer_supervision_alarm && ctrl_reg[`CTRL_FALLBACK_BIT]);
		case (dir_mode)
			// characteristic angle is signed, so its sign is extended
			overcurrent_pkg::DIR_FORWARD: win = in_window(ang, {angle_reg[15], angle_reg[15:8]}, angle_reg[7:0]);
			overcurrent_pkg::DIR_BACKWARD: win = in_window(9'(wrap_deg(sx(ang) - 11'sh0B4)),
				{angle_reg[15], angle_reg[15:8]}, angle_reg[7:0]);
			default: win = 1'b0;
		endcase
		dir_en_next = ff;
		dir_ok_next = switch_onto_fault_condition || nondir || ((fc || ff) && pol_ok && win);
		blocked_next = inhibit || !ctrl_reg[`CTRL_EN_BIT] ||
			(voltage_transformer_supervision_alarm && !ctrl_reg[`CTRL_FALLBACK_BIT]);
		maxmag = 16'h0000;
		for (int p = 0; p < 3; p++) begin
			mag = ctrl_reg[`CTRL_RMS_BIT] ? phase_i_rms[p] : phase_i_fourier[p];
			st[p] = mag > start_reg && dir_ok_next && !blocked_next;
			if (mag > maxmag) begin
				maxmag = mag;
			end
		end
		start_phase_next = meas_valid ? st : start_phase_reg;
		gstart_next = meas_valid ? |st : gstart_reg;
		sotf_next = meas_valid ? switch_onto_fault_condition : sotf_reg;
		found_next = meas_valid ? (ff || fc) : found_reg;
		sel_next = meas_valid ? s : sel_reg;
		angle_out_next = meas_valid ? ang : angle_out_reg;
		excess_next = meas_valid ? (maxmag > start_reg ? maxmag - start_reg : 16'h0000) : excess_reg;
		if (!meas_valid) begin
			dir_en_next = dir_en_reg;
			dir_ok_next = dir_ok_reg;
			blocked_next = blocked_reg;
		end
		// pre-fault memory refreshed only from a healthy positive sequence
		mem_ang_next = meas_valid && pos_ok ? posseq_v_ang : mem_ang_reg;
		mem_valid_next = mem_valid_reg || (meas_valid && pos_ok);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_phase_reg <= 3'h0;
			gstart_reg <= 1'b0;
			sotf_reg <= 1'b0;
			dir_ok_reg <= 1'b0;
			dir_en_reg <= 1'b0;
			found_reg <= 1'b0;
			blocked_reg <= 1'b1;
			sel_reg <= 3'h0;
			angle_out_reg <= 9'h000;
			excess_reg <= 16'h0000;
			mem_ang_reg <= 9'h000;
			mem_valid_reg <= 1'b0;
		end else begin
			start_phase_reg <= start_phase_next;
			gstart_reg <= gstart_next;
			sotf_reg <= sotf_next;
			dir_ok_reg <= dir_ok_next;
			dir_en_reg <= dir_en_next;
			found_reg <= found_next;
			blocked_reg <= blocked_next;
			sel_reg <= sel_next;
			angle_out_reg <= angle_out_next;
			excess_reg <= excess_next;
			mem_ang_reg <= mem_ang_next;
			mem_valid_reg <= mem_valid_next;
		end
	end

	// definite counts ms, inverse integrates excess current per ms
	assign thr = ctrl_reg[`CTRL_INV_BIT] ? 32'(delay_reg) * 32'(start_reg) : 32'(delay_reg);
	always_comb begin
		tm_next = tm_reg;
		tick_next = tick_reg;
		acc_next = acc_reg;
		case (tm_reg)
			overcurrent_pkg::TM_IDLE: begin
				tick_next = 16'h0000;
				acc_next = 32'h0000_0000;
				if (gstart_reg) begin
					tm_next = overcurrent_pkg::TM_RUN;
				end
			end
			overcurrent_pkg::TM_RUN: begin
				if (tick_reg == 16'(TICK_CYCLES - 1)) begin
					tick_next = 16'h0000;
					acc_next = acc_reg + (ctrl_reg[`CTRL_INV_BIT] ? 32'(excess_reg) : 32'h0000_0001);
				end else begin
					tick_next = tick_reg + 16'h0001;
				end
				// delay elapsed, or none under switch-onto-fault
				if (sotf_reg || acc_reg >= thr) begin
					tm_next = overcurrent_pkg::TM_TRIP;
				end
			end
			overcurrent_pkg::TM_TRIP: acc_next = acc_reg;
			default: tm_next = overcurrent_pkg::TM_IDLE;
		endcase
		// losing the start drops the timer, a partial delay does not accumulate
		if (!gstart_reg) begin
			tm_next = overcurrent_pkg::TM_IDLE;
		end
		// trip only while started and direction holds
		trip_next = tm_next == overcurrent_pkg::TM_TRIP && gstart_reg && dir_ok_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tm_reg <= overcurrent_pkg::TM_IDLE;
			tick_reg <= 16'h0000;
			acc_reg <= 32'h0000_0000;
			trip_reg <= 1'b0;
		end else begin
			tm_reg <= tm_next;
			tick_reg <= tick_next;
			acc_reg <= acc_next;
			trip_reg <= trip_next;
		end
	end

	assign start_phase = start_phase_reg;
	assign general_start = gstart_reg;
	assign trip = trip_reg;
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// checks on the evaluation and timing
	a_inhibit_blocks: assert property (@(posedge pclk) disable iff (!presetn)
		meas_valid && inhibit |=> !general_start && start_phase == 3'h0 ##1 !trip) else $error("start under inhibit");
	a_disable_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		meas_valid && !ctrl_reg[`CTRL_EN_BIT] |=> !general_start ##1 !trip) else $error("start while disabled");
	a_trip_after_start: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(trip) |-> $past(general_start, 1) && $past(general_start, 2)) else $error("trip without start");
	a_sotf_fast_trip: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(general_start) && sotf_reg |-> ##2 trip) else $error("slow switch-onto-fault trip");
	a_general_start_or: assert property (@(posedge pclk) disable iff (!presetn)
		general_start == (start_phase != 3'h0)) else $error("general start mismatch");
	a_isolated_pp_loop: assert property (@(posedge pclk) disable iff (!presetn)
		meas_valid && ctrl_reg[`CTRL_ISO_BIT] && !wr_en |=> !found_reg || sel_reg < 3'h3)
		else $error("neutral loop on isolated network");
	a_vts_blocks: assert property (@(posedge pclk) disable iff (!presetn)
		meas_valid && voltage_transformer_supervision_alarm && !ctrl_reg[`CTRL_FALLBACK_BIT] |=> !general_start)
		else $error("alarm did not block");
	a_nondir_passes: assert property (@(posedge pclk) disable iff (!presetn)
		meas_valid && dir_mode == overcurrent_pkg::DIR_NONDIR |=> dir_ok_reg) else $error("non-directional gated");
	a_dir_enable_min: assert property (@(posedge pclk) disable iff (!presetn)
		dir_en_reg |-> found_reg) else $error("direction enabled without loop");
	a_definite_delay: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(trip) && !$past(sotf_reg) |-> $past(acc_reg) >= $past(thr)) else $error("trip before delay");
	c_trip: cover property (@(posedge pclk) disable iff (!presetn) $rose(trip));
	c_sotf_trip: cover property (@(posedge pclk) disable iff (!presetn) $rose(trip) && sotf_reg);
	c_backward_ok: cover property (@(posedge pclk) disable iff (!presetn)
		dir_mode == overcurrent_pkg::DIR_BACKWARD && dir_ok_reg && found_reg);
endmodule
`default_nettype wire

// ==== sim/measurement_source.sv ====
// Purpose: upstream measurement source feeding the overcurrent block
// Assumes: bench fills vm, va, im, ia, rms, four and flags, then calls strobe
// Notes: values are only valid on the strobe; between strobes every line carries inverted junk
`timescale 1ns/100ps
`default_nettype none
module measurement_source (
	input wire logic pclk,
	output logic meas_valid,
	output logic [5:0][15:0] loop_v_mag,
	output logic [5:0][8:0] loop_v_ang,
	output logic [5:0][15:0] loop_i_mag,
	output logic [5:0][8:0] loop_i_ang,
	output logic [15:0] posseq_v_mag,
	output logic [8:0] posseq_v_ang,
	output logic [2:0][15:0] phase_i_rms,
	output logic [2:0][15:0] phase_i_fourier,
	output logic inhibit,
	output logic voltage_transformer_supervision_alarm,
	output logic switch_onto_fault_condition
);
	localparam int W = 424;
	logic [5:0][15:0] vm, im;
	logic [5:0][8:0] va, ia;
	logic [2:0][15:0] rms, four;
	logic [2:0] flags; // inhibit, alarm, switch-onto-fault
	// one image of all lines, inverted when not valid so stale values never look good
	task automatic drive(input logic inv);
		{loop_v_mag, loop_v_ang, loop_i_mag, loop_i_ang, posseq_v_mag, posseq_v_ang, phase_i_rms, phase_i_fourier,
			inhibit, voltage_transformer_supervision_alarm, switch_onto_fault_condition}
			<= {vm, va, im, ia, 16'h03E8, 9'h000, rms, four, flags} ^ {W{inv}};
	endtask
	task automatic strobe();
		@(posedge pclk);
		meas_valid <= 1'b1;
		drive(1'b0);
		@(posedge pclk);
		meas_valid <= 1'b0;
		drive(1'b1);
	endtask
	// strobe low and inverted zeros on every line but posseq_v_mag at time zero
	initial begin
		{vm, va, im, ia, rms, four, flags} = '0;
		meas_valid = 1'b0;
		drive(1'b1);
	end
endmodule
`default_nettype wire

// ==== sim/directional_overcurrent_function_tb.sv ====
// Purpose: self-checking bench for the directional overcurrent block
// Assumes: millisecond tick shortened to 10 cycles
// Notes: starts are noted per strobe and compared by a monitor process
`timescale 1ns/100ps
`default_nettype none
`include "overcurrent_defines.svh"
module directional_overcurrent_function_tb;
	localparam int TICK = 10;
	localparam logic [31:0] RST[5] = '{`CTRL_RESET, 32'(`START_RESET), 32'(`DELAY_RESET), 32'(`ANGLE_RESET),
		`RATED_RESET};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, general_start, trip;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic meas_valid, inhibit, voltage_transformer_supervision_alarm, switch_onto_fault_condition;
	logic [5:0][15:0] loop_v_mag, loop_i_mag;
	logic [5:0][8:0] loop_v_ang, loop_i_ang;
	logic [15:0] posseq_v_mag;
	logic [8:0] posseq_v_ang;
	logic [2:0][15:0] phase_i_rms, phase_i_fourier;
	logic [2:0] start_phase;
	logic [3:0] notes[$];
	int failures, cmp_count, n;
	directional_overcurrent_function #(.TICK_CYCLES(TICK)) i_dut (.pclk, .presetn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .meas_valid, .loop_v_mag, .loop_v_ang, .loop_i_mag,
		.loop_i_ang, .posseq_v_mag, .posseq_v_ang, .phase_i_rms, .phase_i_fourier, .inhibit,
		.voltage_transformer_supervision_alarm, .switch_onto_fault_condition, .start_phase, .general_start, .trip);
	measurement_source i_src (.pclk, .meas_valid, .loop_v_mag, .loop_v_ang, .loop_i_mag, .loop_i_ang,
		.posseq_v_mag, .posseq_v_ang, .phase_i_rms, .phase_i_fourier, .inhibit,
		.voltage_transformer_supervision_alarm, .switch_onto_fault_condition);
	// 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// one apb transfer; the request is held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		failures += int'(k >= 50);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// control word: enable always set, so callers only choose the modes
	function automatic logic [31:0] cw(input logic iso, input logic [1:0] dir, input logic fb, input logic rms,
		input logic inv);
		return {25'h0, inv, rms, fb, dir, iso, 1'b1};
	endfunction
	// one faulty loop; healthy loops carry too little current to qualify
	task automatic fault(input int lp, input int ang, input logic [15:0] cur);
		for (int k = 0; k < 6; k++) begin
			i_src.vm[k] = 16'h03E8;
			i_src.va[k] = 9'h000;
			i_src.im[k] = 16'h000A;
			i_src.ia[k] = 9'h000;
		end
		i_src.vm[lp] = 16'h00C8;
		i_src.va[lp] = ang[8:0];
		i_src.im[lp] = cur;
		i_src.four = {3{16'h0010}};
		i_src.four[0] = 16'h0200 + 16'($urandom % 256);
		i_src.rms = i_src.four;
		i_src.flags = 3'b000;
	endtask
	task automatic meas(input logic [2:0] sp);
		notes.push_back({sp, |sp});
		i_src.strobe();
	endtask
	// drop the fault so start, timer and trip all clear
	task automatic quiet();
		fault(3, 60, 16'h0200);
		i_src.four[0] = 16'h0010;
		i_src.rms[0] = 16'h0010;
		meas(3'b000);
	endtask
	task automatic wait_trip();
		n = 0;
		while (trip !== 1'b1 && n < 2000) begin
			@(negedge pclk);
			n++;
		end
	endtask
	// monitor: every strobe answers with starts one cycle later
	initial begin
		forever begin
			@(posedge pclk);
			if (meas_valid === 1'b1) begin
				@(negedge pclk);
				check("starts", {start_phase, general_start}, notes.pop_front());
			end
		end
	end
	// watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		$display("watchdog expired");
		give_verdict();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, failures, cmp_count} = '0;
		void'($urandom(99578));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			apb(1'b0, 8'(4 * k), 32'h0);
			check("reset_value", rd, RST[k]);
		end
		apb(1'b0, 8'h18, 32'h0);
		check("unmapped_err", {31'h0, err}, 32'h1);
		check("unmapped_data", rd, 32'h0);
		apb(1'b1, `OFS_STATUS, 32'hFFFF_FFFF);
		check("status_write", {31'h0, err}, 32'h1);
		apb(1'b1, `OFS_DELAY, 32'h2);
		apb(1'b0, `OFS_DELAY, 32'h0);
		check("delay_rw", rd, 32'h2);
		$display("test registers done");
		fault(3, 60, 16'h0200);
		meas(3'b000);
		apb(1'b1, `OFS_CTRL, cw(1'b0, overcurrent_pkg::DIR_FORWARD, 1'b0, 1'b0, 1'b0));
		fault(3, 20 + int'($urandom % 81), 16'h0200);
		meas(3'b001);
		wait_trip();
		check("definite_delay", 32'(n >= 2 * TICK - 2 && n < 6 * TICK), 32'h1);
		quiet();
		$display("test forward trip done");
		// every direction code against a forward and a backward fault
		for (int m = 0; m < 4; m++) begin
			for (int b = 0; b < 2; b++) begin
				apb(1'b1, `OFS_CTRL, cw(1'b0, 2'(m), 1'b0, 1'b0, 1'b0));
				fault(3, b ? -120 : 60, 16'h0200);
				meas({2'b00, m == 0 || (m == 1 && b == 0) || (m == 2 && b == 1)});
			end
		end
		$display("test directions done");
		// flags: inhibit, alarm blocking, alarm fallback, switch-onto-fault
		for (int f = 0; f < 4; f++) begin
			// a fresh start lets the switch-onto-fault trip be timed from its rise
			if (f == 3) begin
				quiet();
			end
			apb(1'b1, `OFS_CTRL, cw(1'b0, overcurrent_pkg::DIR_FORWARD, f == 2, 1'b0, 1'b0));
			apb(1'b1, `OFS_DELAY, f == 3 ? 32'd100 : 32'd2);
			fault(3, f < 2 ? 60 : -120, 16'h0200);
			i_src.flags = f == 0 ? 3'b100 : f == 3 ? 3'b001 : 3'b010;
			meas({2'b00, f >= 2});
		end
		wait_trip();
		check("fast_trip", 32'(n < 10), 32'h1);
		quiet();
		$display("test binary inputs done");
		// current minimum boundary on the fault loop
		for (int c = 0; c < 2; c++) begin
			apb(1'b1, `OFS_CTRL, cw(1'b0, overcurrent_pkg::DIR_FORWARD, 1'b0, 1'b0, 1'b0));
			fault(3, 60, 16'h004F + 16'(c));
			meas({2'b00, c == 1});
		end
		// weak loop voltage with a wrong-way loop angle: positive sequence polarizes instead
		fault(3, -120, 16'h0200);
		i_src.vm[3] = 16'h0032;
		i_src.ia[3] = 9'h1EC;
		meas(3'b001);
		apb(1'b0, `OFS_STATUS, 32'h0);
		check("status_word", rd, 32'h0014_0569);
		// lowest impedance loop is wrong-way; isolated setting sees only the line loop
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, `OFS_CTRL, cw(s == 1, overcurrent_pkg::DIR_FORWARD, 1'b0, 1'b0, 1'b0));
			fault(3, -120, 16'h0200);
			i_src.vm[0] = 16'h0258;
			i_src.va[0] = 9'h03C;
			i_src.im[0] = 16'h0200;
			meas({2'b00, s == 1});
		end
		// phase two high only in its rms value
		for (int r = 0; r < 2; r++) begin
			apb(1'b1, `OFS_CTRL, cw(1'b0, overcurrent_pkg::DIR_FORWARD, 1'b0, r == 1, 1'b0));
			fault(3, 60, 16'h0200);
			i_src.four[0] = 16'h0010;
			i_src.rms[0] = 16'h0010;
			i_src.rms[1] = 16'h0300;
			meas({1'b0, r == 1, 1'b0});
		end
		$display("test loop selection done");
		quiet();
		apb(1'b1, `OFS_CTRL, cw(1'b0, overcurrent_pkg::DIR_FORWARD, 1'b0, 1'b0, 1'b1));
		apb(1'b1, `OFS_DELAY, 32'h2);
		fault(3, 60, 16'h0200);
		i_src.four[0] = 16'h0300;
		meas(3'b001);
		wait_trip();
		check("inverse_trip", 32'(n < 2 * TICK - 2), 32'h1);
		quiet();
		$display("test inverse curve done");
		repeat (5) @(posedge pclk);
		give_verdict();
	end
endmodule
`default_nettype wire
